// File: cap_field_pack.sv
// Assembles the two capability words from their fields.
// Assumes field values are constants or same-clock levels; reserved bits are forced to zero.
`timescale 1ns/1ns
`include "hs_cap_defines.svh"

module cap_field_pack (
  input wire logic [15:0] version_i,
  input wire logic [7:0] cap_length_i,
  input wire hs_cap_pkg::nibble_t companion_count_i,
  input wire hs_cap_pkg::nibble_t ports_per_companion_i,
  input wire logic port_routing_rule_i,
  input wire logic port_power_switch_present_i,
  input wire hs_cap_pkg::nibble_t port_count_i,
  output hs_cap_pkg::word_t version_word_o,
  output hs_cap_pkg::word_t struct_word_o
);
  import hs_cap_pkg::*;

  // Start from zero so every reserved range reads as zero.
  always_comb begin
    version_word_o = `WORD_ZERO;
    version_word_o[`VER_MSB:`VER_LSB] = version_i; // RULE1
    version_word_o[`LEN_MSB:`LEN_LSB] = cap_length_i; // RULE2
    struct_word_o = `WORD_ZERO; // RULE14
    struct_word_o[`NCC_MSB:`NCC_LSB] = companion_count_i; // RULE4
    struct_word_o[`NPCC_MSB:`NPCC_LSB] = ports_per_companion_i; // RULE6
    struct_word_o[`ROUTE_RULE_BIT] = port_routing_rule_i; // RULE8
    struct_word_o[`POWER_SW_BIT] = port_power_switch_present_i; // RULE10
    struct_word_o[`NP_MSB:`NP_LSB] = port_count_i; // RULE12
  end

endmodule // cap_field_pack

// File: hs_cap_defines.svh
// Constants of the high-speed host capability register bank: offsets, field positions,
// reset values and decode windows.
// Assumes it is included by its bare name from the package and the design modules.
//
// Summary of operation
// [RULE1] Word 0 bits 31..16 return the BCD interface version, value 0100h.
// [RULE2] Word 0 bits 7..0 return capability space length 20h, offset to operational space.
// [RULE3] Both words read at the function memory base, byte offsets 00h and 04h.
// [RULE4] Companion count zero means no companions, no hand-off, high-speed devices only.
// [RULE5] Nonzero companion count means companions exist and port hand-off is supported.
// [RULE6] Ports-per-companion field tells software how many root ports each companion serves.
// [RULE7] Ports-per-companion times companion count must cover every downstream port.
// [RULE8] Routing bit 0: consecutive port groups go to companions in ascending order.
// [RULE9] Routing bit 1: each port's companion comes from the port-route array entries.
// [RULE10] Port power bit reads 1 with power switches, 0 without them.
// [RULE11] Per-port power bit behaviour follows the reported power switch presence.
// [RULE12] Port count reports implemented ports and limits which per-port registers decode.
// [RULE13] Port count is never reported as zero.
// [RULE14] Both registers are read-only; writes ignored; reserved bits read zero.
// [RULE15] Capability registers sit just before the operational registers in memory space.

`ifndef HS_CAP_DEFINES_SVH
`define HS_CAP_DEFINES_SVH

`define MAX_PORTS 15
`define WORD_ZERO 32'h0000_0000
`define OFS_VERSION_WORD 32'h0000_0000
`define OFS_STRUCT_WORD 32'h0000_0004
`define IFACE_VERSION 16'h0100
`define CAP_LENGTH 8'h20
`define BAR_SPAN 32'h0000_0400
`define PORTSC_BASE 32'h0000_0044
`define PORTSC_SHIFT 2
`define VER_MSB 31
`define VER_LSB 16
`define RSV0_MSB 15
`define RSV0_LSB 8
`define LEN_MSB 7
`define LEN_LSB 0
`define RSV1_MSB 31
`define RSV1_LSB 16
`define NCC_MSB 15
`define NCC_LSB 12
`define NPCC_MSB 11
`define NPCC_LSB 8
`define ROUTE_RULE_BIT 7
`define RSV2_MSB 6
`define RSV2_LSB 5
`define POWER_SW_BIT 4
`define NP_MSB 3
`define NP_LSB 0

`endif

// File: hs_cap_pkg.sv
// Types and shared decode helpers of the capability register bank.
// Assumes the defines header is on the include path.
`include "hs_cap_defines.svh"

package hs_cap_pkg;

  typedef logic [31:0] word_t;
  typedef logic [3:0] nibble_t;
  typedef logic [`MAX_PORTS*4-1:0] owner_t;
  typedef logic [`MAX_PORTS-1:0] portmask_t;

  // Whole state of the register bank, registered as one packed vector.
  typedef struct packed {
    word_t rdata;
    logic ack;
    logic op_sel;
    word_t op_offset;
    logic port_sel;
    nibble_t port_index;
    owner_t owner;
    portmask_t port_valid;
    logic handoff;
    logic power_forced;
  } state_s;

  // Unsigned window test used by the window and port-slot decodes in the bank.
  function automatic logic below(input word_t a, input word_t lim);
    return a < lim;
  endfunction

endpackage : hs_cap_pkg

// File: hs_host_capability_regs.sv
// Read-only capability register bank of the high-speed host function, with the memory
// decode that splits the function's window into capability and operational space.
// Assumes bar_base_i comes from the configuration block on the same clock, and that
// requests are single-cycle strobes from the bus target logic on the same clock.
`timescale 1ns/1ns
`include "hs_cap_defines.svh"

module hs_host_capability_regs #(
  parameter int NUM_PORTS = 2,
  parameter int NUM_COMPANIONS = 2,
  parameter int PORTS_PER_COMPANION = 1,
  parameter bit ROUTING_RULE = 1'b0,
  parameter bit PORT_POWER_SWITCHES = 1'b1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire hs_cap_pkg::word_t bar_base_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire hs_cap_pkg::word_t mem_addr_i,
  input wire logic [3:0] mem_be_i,
  input wire hs_cap_pkg::word_t mem_wdata_i,
  input wire hs_cap_pkg::owner_t port_route_i,
  output hs_cap_pkg::word_t mem_rdata_o,
  output logic mem_ack_o,
  output logic op_sel_o,
  output hs_cap_pkg::word_t op_offset_o,
  output logic port_sel_o,
  output hs_cap_pkg::nibble_t port_index_o,
  output hs_cap_pkg::owner_t port_owner_o,
  output hs_cap_pkg::portmask_t port_valid_o,
  output logic handoff_supported_o,
  output logic port_power_forced_o
);
  import hs_cap_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////
  // Reported structure.
  //////////////////////////////////////////////////////////////////////////////////////

  // A port count of zero is meaningless, so the field is clamped to at least one port.
  localparam int PORTS_EFF = (NUM_PORTS < 1) ? 1 : NUM_PORTS;
  localparam nibble_t PORT_COUNT = 4'(PORTS_EFF); // RULE13
  localparam nibble_t COMPANIONS = 4'(NUM_COMPANIONS);
  localparam nibble_t GROUP_SIZE = 4'(PORTS_PER_COMPANION);
  // Grouping must reach every port; otherwise some ports would have no companion.
  // The value is checked rather than forced, so a bad parameter set shows up in the checks.
  localparam bit ROUTE_COVERS = (NUM_COMPANIONS == 0) ||
                                (NUM_COMPANIONS * PORTS_PER_COMPANION >= PORTS_EFF); // RULE7
  localparam word_t CAP_LEN_W = {24'h00_0000, `CAP_LENGTH};
  localparam word_t PORT_SPAN = word_t'(PORTS_EFF) << `PORTSC_SHIFT;

  word_t version_word;
  word_t struct_word;
  owner_t owner_w;
  portmask_t valid_w;

  // Field assembly kept apart so the word layout is read in one place.
  cap_field_pack u_pack (
    .version_i(`IFACE_VERSION),
    .cap_length_i(`CAP_LENGTH),
    .companion_count_i(COMPANIONS),
    .ports_per_companion_i(GROUP_SIZE),
    .port_routing_rule_i(ROUTING_RULE),
    .port_power_switch_present_i(PORT_POWER_SWITCHES),
    .port_count_i(PORT_COUNT),
    .version_word_o(version_word),
    .struct_word_o(struct_word)
  );

  // Port ownership map, grouped or explicit as the routing bit says.
  port_route_map #(
    .NUM_PORTS(PORTS_EFF),
    .PORTS_PER_COMPANION(PORTS_PER_COMPANION),
    .ROUTING_RULE(ROUTING_RULE)
  ) u_route (
    .port_route_i(port_route_i),
    .owner_o(owner_w),
    .valid_o(valid_w)
  );

  //////////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  //////////////////////////////////////////////////////////////////////////////////////

  word_t offset;
  word_t op_off;
  word_t port_off;
  logic in_bar;
  logic in_cap;
  logic aligned;
  logic hit_version;
  logic hit_struct;
  logic cap_hit;
  logic op_hit;
  logic port_hit;
  word_t read_word;

  // The capability block occupies the bottom of the window; the operational space
  // starts at the capability length, and per-port slots exist only for real ports.
  // The offset is a plain difference, so an address below the base wraps to a huge
  // value and falls outside the window instead of aliasing onto a capability word.
  always_comb begin
    offset = mem_addr_i - bar_base_i;
    in_bar = below(offset, `BAR_SPAN);
    in_cap = below(offset, CAP_LEN_W); // RULE15
    aligned = (offset[1:0] == 2'b00);
    hit_version = in_bar && (offset == `OFS_VERSION_WORD); // RULE3
    hit_struct = in_bar && (offset == `OFS_STRUCT_WORD); // RULE3
    cap_hit = hit_version || hit_struct;
    op_off = offset - CAP_LEN_W;
    op_hit = in_bar && !in_cap; // RULE15
    port_off = op_off - `PORTSC_BASE;
    port_hit = op_hit && aligned && !below(op_off, `PORTSC_BASE) && below(port_off, PORT_SPAN); // RULE12
    read_word = hit_version ? version_word : struct_word;
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // State.
  //////////////////////////////////////////////////////////////////////////////////////

  state_s s_r;
  state_s s_nxt;

  // Writes are acknowledged so the bus never hangs, but they change nothing.
  // Byte enables and write data are deliberately not read: every field is fixed, and
  // a read always returns the whole word whatever lanes the master asked for.
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.op_sel = 1'b0;
    s_nxt.port_sel = 1'b0;
    s_nxt.owner = owner_w;
    s_nxt.port_valid = valid_w;
    s_nxt.handoff = (COMPANIONS != 4'h0); // RULE5
    s_nxt.power_forced = !PORT_POWER_SWITCHES; // RULE11
    if (mem_req_i && cap_hit) begin
      s_nxt.ack = 1'b1;
      if (!mem_we_i) begin
        s_nxt.rdata = read_word; // RULE14
      end
    end else if (mem_req_i && op_hit) begin
      s_nxt.op_sel = 1'b1;
      s_nxt.op_offset = op_off; // RULE15
      if (port_hit) begin
        s_nxt.port_sel = 1'b1;
        s_nxt.port_index = port_off[`PORTSC_SHIFT +: 4];
      end
    end
  end

  // Synchronous reset clears the whole state; the fixed fields load one edge later.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign mem_rdata_o = s_r.rdata;
  assign mem_ack_o = s_r.ack;
  assign op_sel_o = s_r.op_sel;
  assign op_offset_o = s_r.op_offset;
  assign port_sel_o = s_r.port_sel;
  assign port_index_o = s_r.port_index;
  assign port_owner_o = s_r.owner;
  assign port_valid_o = s_r.port_valid;
  assign handoff_supported_o = s_r.handoff; // RULE4
  assign port_power_forced_o = s_r.power_forced;

  //////////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  //////////////////////////////////////////////////////////////////////////////////////

  // Helper: true one cycle after reset has been released for at least one edge.
  // It keeps the level checks quiet on the edge where the state is still loading.
  logic live_r;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // The version half-word carries the fixed BCD version and the read is acknowledged.
  a_version_readback: assert property ( // RULE1
    mem_req_i && !mem_we_i && hit_version |=>
      mem_ack_o && mem_rdata_o[`VER_MSB:`VER_LSB] == `IFACE_VERSION)
    else $error("Version field read back wrong.");

  // The length byte is the fixed capability length.
  a_length_readback: assert property ( // RULE2
    mem_req_i && !mem_we_i && hit_version |=> mem_rdata_o[`LEN_MSB:`LEN_LSB] == `CAP_LENGTH)
    else $error("Capability length read back wrong.");

  // Offset 04h above the base answers as a capability access, not as operational space.
  a_cap_decode: assert property ( // RULE3
    mem_req_i && (mem_addr_i - bar_base_i == `OFS_STRUCT_WORD) |=> mem_ack_o && !op_sel_o)
    else $error("Structural word at offset 04h not acknowledged.");

  // With a zero companion count, hand-off support stays off once the state has loaded.
  a_handoff_zero: assert property ( // RULE4
    live_r && (COMPANIONS == 4'h0) |-> !handoff_supported_o)
    else $error("Hand-off claimed with no companions.");

  // A nonzero companion count means hand-off must be offered.
  a_handoff_nonzero: assert property ( // RULE5
    live_r |-> handoff_supported_o == (struct_word[`NCC_MSB:`NCC_LSB] != 4'h0))
    else $error("Hand-off flag disagrees with companion count.");

  // The group size field reads back as configured.
  a_group_field: assert property ( // RULE6
    mem_req_i && !mem_we_i && hit_struct |=> mem_rdata_o[`NPCC_MSB:`NPCC_LSB] == GROUP_SIZE)
    else $error("Ports-per-companion field wrong.");

  // Every real port maps to an existing companion when groups are used.
  a_route_covers: assert property ( // RULE7
    live_r && !ROUTING_RULE && (COMPANIONS != 4'h0) |->
      ROUTE_COVERS && port_owner_o[(PORTS_EFF-1)*4 +: 4] < COMPANIONS)
    else $error("Port grouping leaves a port without a companion.");

  // With grouping, the port just past the first group belongs to the next companion.
  a_route_group: assert property ( // RULE8
    live_r && !ROUTING_RULE && (PORTS_PER_COMPANION > 0) && (PORTS_PER_COMPANION < `MAX_PORTS) |->
      port_owner_o[3:0] == 4'h0 && port_owner_o[PORTS_PER_COMPANION*4 +: 4] == 4'h1)
    else $error("Grouped routing assigns the wrong companion.");

  // With explicit routing the owner of port 0 follows the array one cycle later.
  a_route_explicit: assert property ( // RULE9
    live_r && ROUTING_RULE |=> port_owner_o[3:0] == $past(port_route_i[3:0]))
    else $error("Explicit routing not taken from the route array.");

  // The power switch bit and the forced-power output are complements.
  a_power_bit: assert property ( // RULE10
    mem_req_i && !mem_we_i && hit_struct |=> mem_rdata_o[`POWER_SW_BIT] == !port_power_forced_o)
    else $error("Power switch bit disagrees with forced-power output.");

  a_power_forced: assert property ( // RULE11
    live_r |-> port_power_forced_o == !PORT_POWER_SWITCHES)
    else $error("Port power behaviour does not follow switch presence.");

  // A port slot is selected only with an operational select, and only for ports that exist.
  a_port_decode: assert property ( // RULE12
    port_sel_o |-> op_sel_o && port_index_o < PORT_COUNT && port_valid_o[port_index_o])
    else $error("Per-port register selected beyond the port count.");

  a_ports_nonzero: assert property ( // RULE13
    mem_req_i && !mem_we_i && hit_struct |=> mem_rdata_o[`NP_MSB:`NP_LSB] != 4'h0)
    else $error("Port count read as zero.");

  // A write leaves the read data untouched, and reserved bits of either word read zero.
  a_write_ignored: assert property ( // RULE14
    mem_req_i && mem_we_i && cap_hit |=> mem_ack_o && $stable(mem_rdata_o))
    else $error("Write changed the read-only capability data.");

  a_reserved_zero: assert property ( // RULE14
    mem_req_i && !mem_we_i && cap_hit |=>
      (hit_version ? 1'b1 : 1'b1) && ($past(hit_version) ?
        mem_rdata_o[`RSV0_MSB:`RSV0_LSB] == 8'h00 :
        mem_rdata_o[`RSV1_MSB:`RSV1_LSB] == 16'h0000 && mem_rdata_o[`RSV2_MSB:`RSV2_LSB] == 2'b00))
    else $error("Reserved bits read nonzero.");

  // Operational space begins exactly at the capability length.
  a_op_after_cap: assert property ( // RULE15
    mem_req_i && in_bar |=> op_sel_o == !$past(in_cap) ##0
      (!op_sel_o || op_offset_o == $past(offset) - CAP_LEN_W))
    else $error("Operational space does not start at the capability length.");

  // Offsets 08h to 1Fh belong to registers kept outside this bank, so nothing answers.
  a_gap_silent: assert property ( // RULE3
    mem_req_i && in_cap && !cap_hit |=> !mem_ack_o && !op_sel_o)
    else $error("Unclaimed capability offset was answered.");

  // With no request the next edge shows no strobe of any kind.
  a_no_spurious: assert property ( // RULE15
    !mem_req_i |=> !mem_ack_o && !op_sel_o && !port_sel_o)
    else $error("Answer strobe raised without a request.");

  // A capability answer and an operational select never appear together.
  a_strobe_exclusive: assert property ( // RULE15
    mem_ack_o |-> !op_sel_o && !port_sel_o)
    else $error("Capability answer and operational select overlap.");

  // The port count field reads back as the clamped parameter.
  a_port_count: assert property ( // RULE12
    mem_req_i && !mem_we_i && hit_struct |=> mem_rdata_o[`NP_MSB:`NP_LSB] == PORT_COUNT)
    else $error("Port count field read back wrong.");

  //////////////////////////////////////////////////////////////////////////////////////
  // Coverage: each cover marks one access kind that the bench must reach.
  //////////////////////////////////////////////////////////////////////////////////////

  c_read_version: cover property (mem_req_i && !mem_we_i && hit_version ##1 mem_ack_o);
  c_read_struct: cover property (mem_req_i && !mem_we_i && hit_struct ##1 mem_ack_o);
  c_write_cap: cover property (mem_req_i && mem_we_i && cap_hit ##1 mem_ack_o);
  c_port_access: cover property (mem_req_i && port_hit ##1 port_sel_o);
  c_op_plain: cover property (mem_req_i && op_hit && !port_hit ##1 op_sel_o && !port_sel_o);

endmodule // hs_host_capability_regs

// File: port_route_map.sv
// Works out which companion controller owns each root port, and which ports exist.
// Assumes the explicit route array is a same-clock level from the route register block.
`timescale 1ns/1ns
`include "hs_cap_defines.svh"

module port_route_map #(
  parameter int NUM_PORTS = 2,
  parameter int PORTS_PER_COMPANION = 1,
  parameter bit ROUTING_RULE = 1'b0
) (
  input wire hs_cap_pkg::owner_t port_route_i,
  output hs_cap_pkg::owner_t owner_o,
  output hs_cap_pkg::portmask_t valid_o
);
  import hs_cap_pkg::*;

  // A zero group size would divide by zero; treat it as one port per group.
  localparam int GROUP = (PORTS_PER_COMPANION < 1) ? 1 : PORTS_PER_COMPANION;

  // One owner nibble per port slot; the group owner is fixed at elaboration.
  for (genvar i = 0; i < `MAX_PORTS; i++) begin : g_port
    localparam logic [3:0] GROUP_OWNER = 4'((i / GROUP));
    if (ROUTING_RULE) begin : g_explicit
      assign owner_o[i*4 +: 4] = port_route_i[i*4 +: 4]; // RULE9
    end else begin : g_grouped
      assign owner_o[i*4 +: 4] = GROUP_OWNER; // RULE8
    end
    assign valid_o[i] = (i < NUM_PORTS); // RULE12
  end

endmodule // port_route_map

// File: tb_top.sv
// Self-checking bench of the capability register bank: two instances with opposite settings.
// Assumes the design files and the defines header are compiled first.
`timescale 1ns/1ns
`include "hs_cap_defines.svh"

module tb_top;
  import hs_cap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Settings of the two instances; expected words are built from them.
  localparam int NP_A = 4;
  localparam int NC_A = 2;
  localparam int PC_A = 2;
  localparam bit RR_A = 1'b0;
  localparam bit PW_A = 1'b1;
  localparam int NP_B = 3;
  localparam bit RR_B = 1'b1;
  localparam bit PW_B = 1'b0;
  localparam logic [31:0] VER_WORD = {16'h0100, 8'h00, 8'h20};
  localparam logic [31:0] SA = {16'h0000, 4'(NC_A), 4'(PC_A), RR_A, 2'b00, PW_A, 4'(NP_A)};
  localparam logic [31:0] SB = {16'h0000, 4'h0, 4'h0, RR_B, 2'b00, PW_B, 4'(NP_B)};

  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  word_t bar_base_i = 32'h1000_0000;
  logic mem_req_i = 1'b0;
  logic mem_we_i = 1'b0;
  word_t mem_addr_i = 32'h0000_0000;
  logic [3:0] mem_be_i = 4'hf;
  word_t mem_wdata_i = 32'h0000_0000;
  owner_t port_route_i = 60'h0000_0000_0000_213;
  word_t rd_a, rd_b, ofs_a, ofs_b;
  logic ack_a, ack_b, op_a, op_b, ps_a, ps_b, ho_a, ho_b, pf_a, pf_b;
  nibble_t pi_a, pi_b;
  owner_t own_a, own_b;
  portmask_t val_a, val_b;
  int fails = 0;
  int checks_done = 0;

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Instance A uses grouped routing with switches; B uses the explicit array, no companions.
  hs_host_capability_regs #(.NUM_PORTS(NP_A), .NUM_COMPANIONS(NC_A), .PORTS_PER_COMPANION(PC_A),
    .ROUTING_RULE(RR_A), .PORT_POWER_SWITCHES(PW_A)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .bar_base_i(bar_base_i), .mem_req_i(mem_req_i),
    .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_be_i(mem_be_i), .mem_wdata_i(mem_wdata_i),
    .port_route_i(port_route_i), .mem_rdata_o(rd_a), .mem_ack_o(ack_a), .op_sel_o(op_a),
    .op_offset_o(ofs_a), .port_sel_o(ps_a), .port_index_o(pi_a), .port_owner_o(own_a),
    .port_valid_o(val_a), .handoff_supported_o(ho_a), .port_power_forced_o(pf_a));

  hs_host_capability_regs #(.NUM_PORTS(NP_B), .NUM_COMPANIONS(0), .PORTS_PER_COMPANION(0),
    .ROUTING_RULE(RR_B), .PORT_POWER_SWITCHES(PW_B)) dut_b (
    .clk_i(clk_i), .nrst_i(nrst_i), .bar_base_i(bar_base_i), .mem_req_i(mem_req_i),
    .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_be_i(mem_be_i), .mem_wdata_i(mem_wdata_i),
    .port_route_i(port_route_i), .mem_rdata_o(rd_b), .mem_ack_o(ack_b), .op_sel_o(op_b),
    .op_offset_o(ofs_b), .port_sel_o(ps_b), .port_index_o(pi_b), .port_owner_o(own_b),
    .port_valid_o(val_b), .handoff_supported_o(ho_b), .port_power_forced_o(pf_b));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value; case inequality so an unknown never passes.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // One access at the falling edge; the request stays up so calls may run back to back.
  task automatic access(input logic we, input word_t ofs);
    mem_req_i = 1'b1;
    mem_we_i = we;
    mem_addr_i = bar_base_i + ofs;
    mem_wdata_i = 32'hffff_ffff;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Drop the request and let one edge pass.
  task automatic idle();
    mem_req_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Read a capability word from both instances and compare the answer.
  task automatic rd_word(input word_t ofs, input word_t ea, input word_t eb);
    access(1'b0, ofs);
    check(64'(ack_a), 64'd1);
    check(64'(ack_b), 64'd1);
    check(64'(op_a), 64'd0);
    check(64'(rd_a), 64'(ea));
    check(64'(rd_b), 64'(eb));
  endtask

  // An address that neither instance claims: no answer of either kind.
  task automatic no_claim(input word_t ofs);
    access(1'b0, ofs);
    check(64'({ack_a, op_a, ack_b, op_b}), 64'd0);
  endtask

  // Operational-space access; slot says whether a port slot with this index is expected.
  task automatic op_access(input word_t ofs, input logic slot_a, input logic slot_b, input nibble_t idx);
    access(1'b0, ofs);
    check(64'({op_a, op_b, ack_a, ack_b}), 64'hc);
    check(64'(ofs_a), 64'(ofs - 32'h0000_0020));
    check(64'(ofs_b), 64'(ofs - 32'h0000_0020));
    check(64'({ps_a, ps_b}), 64'({slot_a, slot_b}));
    if (slot_a) begin
      check(64'(pi_a), 64'(idx));
    end
    if (slot_b) begin
      check(64'(pi_b), 64'(idx));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, shared by the main sequence and the watchdog.
  task automatic give_verdict();
    $display("Checks made: %0d, mismatches: %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (9) @(negedge clk_i);
    check(64'({ack_a, op_a, ho_a, rd_a}), 64'd0);
    @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    // Level outputs after release.
    check(64'({ho_a, ho_b}), 64'b10);
    check(64'({pf_a, pf_b}), 64'b01);
    check(64'(val_a), 64'h000f);
    check(64'(val_b), 64'h0007);
    check(64'(own_a[15:0]), 64'h1100);
    check(64'(own_b[11:0]), 64'h213);
    // Back-to-back reads of both words.
    rd_word(32'h0000_0000, VER_WORD, VER_WORD);
    rd_word(32'h0000_0004, SA, SB);
    idle();
    check(64'(rd_a), 64'(SA));
    check(64'(ack_a), 64'd0);
    // Writes are answered but change nothing.
    access(1'b1, 32'h0000_0000);
    check(64'(ack_a), 64'd1);
    check(64'(rd_a), 64'(SA));
    access(1'b1, 32'h0000_0004);
    check(64'(rd_b), 64'(SB));
    rd_word(32'h0000_0000, VER_WORD, VER_WORD);
    rd_word(32'h0000_0004, SA, SB);
    // Places that belong to other registers or lie outside the window.
    no_claim(32'h0000_0008);
    no_claim(32'h0000_001c);
    no_claim(32'h0000_0400);
    no_claim(32'hffff_fffc);
    // Operational space starts right after the capability space.
    op_access(32'h0000_0020, 1'b0, 1'b0, 4'h0);
    op_access(32'h0000_0064, 1'b1, 1'b1, 4'h0);
    op_access(32'h0000_0070, 1'b1, 1'b0, 4'h3);
    op_access(32'h0000_0074, 1'b0, 1'b0, 4'h0);
    op_access(32'h0000_03fc, 1'b0, 1'b0, 4'h0);
    idle();
    // A moved base window follows the new base.
    bar_base_i = 32'h2000_0800;
    @(negedge clk_i);
    rd_word(32'h0000_0000, VER_WORD, VER_WORD);
    rd_word(32'h0000_0004, SA, SB);
    idle();
    // Reset in mid-run with a request present clears the answer.
    nrst_i = 1'b0;
    access(1'b0, 32'h0000_0004);
    check(64'({ack_a, ack_b, ho_a, rd_a}), 64'd0);
    idle();
    nrst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(64'(ho_a), 64'd1);
    rd_word(32'h0000_0004, SA, SB);
    idle();
    give_verdict();
  end

endmodule // tb_top
